// ==== src/fpg_pkg.sv ====
package fpg_pkg;
   // Register byte offsets on the APB slave
   localparam logic [7:0]  ADDR_KEY          = 8'h00;
   localparam logic [7:0]  ADDR_PS_CTRL      = 8'h04;
   localparam logic [7:0]  ADDR_SUPPLY_CTRL  = 8'h08;
   localparam logic [7:0]  ADDR_RESET_CAUSE  = 8'h0c;
   // Field positions
   localparam int          PS_WE_BIT         = 0;
   localparam int          PS_EE_BIT         = 1;
   localparam int          SUP_ON_BIT        = 7;
   localparam int          SUP_HIGH_BIT      = 5;
   localparam int          RC_PORSRC_BIT     = 1;
   localparam int          RC_FAULT_BIT      = 6;
   localparam int          RC_UNUSED_BIT     = 7;
   // Reset values
   localparam logic        RST_SUP_ON        = 1'b1;
   localparam logic        RST_SUP_HIGH      = 1'b0;
   localparam logic        RST_PORSRC        = 1'b0;
   // Key codes and lock-state codes
   localparam logic [7:0]  KEY_FIRST         = 8'ha5;
   localparam logic [7:0]  KEY_SECOND        = 8'hf1;
   localparam logic [1:0]  LK_LOCKED         = 2'h0;
   localparam logic [1:0]  LK_FIRST          = 2'h1;
   localparam logic [1:0]  LK_OPEN           = 2'h2;
   localparam logic [1:0]  LK_DEAD           = 2'h3;
   // Array geometry
   localparam int          FL_AW             = 13;
   localparam int          PAGE_OFS_W        = 9;
   localparam logic [12:0] SHORT_ADDR_MASK   = 13'h00ff;
   localparam logic [7:0]  ERASED_BYTE       = 8'hff;
   // Timing
   localparam int          CLK_MHZ           = 125;
   localparam int          PROG_TIME_US      = 40;
   localparam int          ERASE_TIME_MS     = 20;
   localparam int          PROG_CYC          = PROG_TIME_US * CLK_MHZ;
   localparam int          ERASE_CYC         = ERASE_TIME_MS * 1000 * CLK_MHZ;
   localparam int          CNT_W             = 22;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_READ  = 4'b0010,
      ST_PROG  = 4'b0100,
      ST_ERASE = 4'b1000
   } fpg_state_t;
endpackage

// ==== src/fpg_flash_guard.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpg_flash_guard
   import fpg_pkg::*;
#(
   parameter int unsigned P_PROG_CYC  = PROG_CYC,
   parameter int unsigned P_ERASE_CYC = ERASE_CYC
) (
   input  wire logic             I_CLOCK,
   input  wire logic             I_RST,
   input  wire logic             I_CE,
   input  wire logic             I_SYS_RST,
   input  wire logic             I_PSEL,
   input  wire logic             I_PENABLE,
   input  wire logic             I_PWRITE,
   input  wire logic [7:0]       I_PADDR,
   input  wire logic [31:0]      I_PWDATA,
   output logic      [31:0]      O_PRDATA,
   output logic                  O_PREADY,
   output logic                  O_PSLVERR,
   input  wire logic             I_XWR_REQ,
   input  wire logic             I_XWR_SHORT,
   input  wire logic [FL_AW-1:0] I_XWR_ADDR,
   input  wire logic [7:0]       I_XWR_DATA,
   output logic                  O_XWR_TO_FLASH,
   output logic                  O_CPU_STALL,
   output logic                  O_IRQ_HOLD,
   output logic                  O_FLASH_ERR_RST,
   output logic                  O_FL_RD,
   output logic                  O_FL_WR,
   output logic                  O_FL_ERASE,
   output logic      [FL_AW-1:0] O_FL_ADDR,
   output logic      [7:0]       O_FL_WDATA,
   input  wire logic [7:0]       I_FL_RDATA
);

   fpg_state_t       state_ff;
   fpg_state_t       nxt_state;
   logic [1:0]       lock_ff;
   logic             ps_we_ff;
   logic             ps_ee_ff;
   logic             sup_on_ff;
   logic             sup_high_ff;
   logic             porsrc_ff;
   logic             fault_ff;
   logic             err_pend_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic [FL_AW-1:0] op_addr_ff;
   logic [7:0]       op_data_ff;
   logic [31:0]      prdata_ff;
   logic             pready_ff;
   logic             pslverr_ff;
   logic             stall_ff;
   logic             err_rst_ff;
   logic             fl_rd_ff;
   logic             fl_wr_ff;
   logic             fl_erase_ff;

   logic             apb_acc;
   logic             apb_wr;
   logic             mapped;
   logic             key_wr;
   logic             ps_wr;
   logic             sup_wr;
   logic             rc_wr;
   logic             flash_req;
   logic             supply_ok;
   logic             req_error;
   logic             req_locked;
   logic             req_go;
   logic             op_done;
   logic [FL_AW-1:0] eff_addr;
   logic [31:0]      rd_mux;

   // APB decode; completion is the second access cycle
   assign apb_acc  = I_PSEL & I_PENABLE & pready_ff;
   assign apb_wr   = apb_acc & I_PWRITE;
   assign mapped   = (I_PADDR == ADDR_KEY) | (I_PADDR == ADDR_PS_CTRL) |
                     (I_PADDR == ADDR_SUPPLY_CTRL) | (I_PADDR == ADDR_RESET_CAUSE);
   assign key_wr   = apb_wr & (I_PADDR == ADDR_KEY);
   assign ps_wr    = apb_wr & (I_PADDR == ADDR_PS_CTRL);
   assign sup_wr   = apb_wr & (I_PADDR == ADDR_SUPPLY_CTRL);
   assign rc_wr    = apb_wr & (I_PADDR == ADDR_RESET_CAUSE);

   // Flash path only exists while write-enable steers writes there
   assign flash_req  = I_XWR_REQ & ps_we_ff & state_ff[0] & ~err_pend_ff;
   assign supply_ok  = sup_on_ff & sup_high_ff & porsrc_ff;
   assign req_error  = flash_req & ~supply_ok;
   assign req_locked = flash_req & supply_ok & (lock_ff != LK_OPEN);
   assign req_go     = flash_req & supply_ok & (lock_ff == LK_OPEN) & ~I_SYS_RST;
   assign op_done    = (state_ff[2] | state_ff[3]) & (cnt_ff == '0);

   // Short form carries only the low address byte
   assign eff_addr = I_XWR_SHORT ? (I_XWR_ADDR & SHORT_ADDR_MASK) : I_XWR_ADDR;

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (I_PADDR)
         ADDR_KEY: begin
            rd_mux[1:0] = lock_ff;
         end
         ADDR_PS_CTRL: begin
            rd_mux[PS_WE_BIT] = ps_we_ff;
            rd_mux[PS_EE_BIT] = ps_ee_ff;
         end
         ADDR_SUPPLY_CTRL: begin
            rd_mux[SUP_ON_BIT]   = sup_on_ff;
            rd_mux[SUP_HIGH_BIT] = sup_high_ff;
         end
         ADDR_RESET_CAUSE: begin
            rd_mux[RC_UNUSED_BIT] = 1'b1;
            rd_mux[RC_FAULT_BIT]  = fault_ff;
            rd_mux[RC_PORSRC_BIT] = porsrc_ff;
         end
         default: begin
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else if (I_CE) begin
         if (I_PSEL & I_PENABLE & ~pready_ff) begin
            pready_ff  <= 1'b1;
            pslverr_ff <= ~mapped;
            prdata_ff  <= I_PWRITE ? 32'h0000_0000 : rd_mux;
         end else begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
         end
      end
   end

   // Lock state machine; the system reset is the only way out of dead
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         lock_ff <= LK_LOCKED;
      end else if (I_CE) begin
         if (I_SYS_RST) begin
            lock_ff <= LK_LOCKED;
         end else if (req_locked) begin
            lock_ff <= LK_DEAD;
         end else if (op_done) begin
            lock_ff <= (lock_ff == LK_DEAD) ? LK_DEAD : LK_LOCKED;
         end else if (key_wr) begin
            if (lock_ff == LK_LOCKED && I_PWDATA[7:0] == KEY_FIRST) begin
               lock_ff <= LK_FIRST;
            end else if (lock_ff == LK_FIRST && I_PWDATA[7:0] == KEY_SECOND) begin
               lock_ff <= LK_OPEN;
            end else begin
               lock_ff <= LK_DEAD;
            end
         end
      end
   end

   // Enables hold until software writes them or a system reset clears them
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         ps_we_ff <= 1'b0;
         ps_ee_ff <= 1'b0;
      end else if (I_CE) begin
         if (I_SYS_RST) begin
            ps_we_ff <= 1'b0;
            ps_ee_ff <= 1'b0;
         end else if (ps_wr) begin
            ps_we_ff <= I_PWDATA[PS_WE_BIT];
            ps_ee_ff <= I_PWDATA[PS_EE_BIT];
         end
      end
   end

   // Monitor settings survive a system reset, as the monitor does
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         sup_on_ff   <= RST_SUP_ON;
         sup_high_ff <= RST_SUP_HIGH;
         porsrc_ff   <= RST_PORSRC;
      end else if (I_CE) begin
         if (sup_wr) begin
            sup_on_ff   <= I_PWDATA[SUP_ON_BIT];
            sup_high_ff <= I_PWDATA[SUP_HIGH_BIT];
         end
         if (rc_wr) begin
            porsrc_ff <= I_PWDATA[RC_PORSRC_BIT];
         end
      end
   end

   // Error pulse asks the reset controller for a system reset
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         err_rst_ff <= 1'b0;
      end else if (I_CE) begin
         err_rst_ff <= req_error;
      end
   end

   // Fault flag tells whether the last system reset was ours
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         err_pend_ff <= 1'b0;
         fault_ff    <= 1'b0;
      end else if (I_CE) begin
         if (I_SYS_RST) begin
            fault_ff    <= err_pend_ff | req_error;
            err_pend_ff <= 1'b0;
         end else if (req_error) begin
            err_pend_ff <= 1'b1;
         end
      end
   end

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (req_go && ps_ee_ff) begin
               nxt_state = ST_ERASE;
            end else if (req_go) begin
               nxt_state = ST_READ;
            end
         end
         ST_READ: begin
            nxt_state = ST_PROG;
         end
         ST_PROG, ST_ERASE: begin
            if (cnt_ff == '0) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         state_ff <= ST_IDLE;
      end else if (I_CE) begin
         state_ff <= I_SYS_RST ? ST_IDLE : nxt_state;
      end
   end

   // Array command stream; a read pulse then a write pulse per program, one erase pulse per erase
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         op_addr_ff  <= '0;
         op_data_ff  <= 8'h00;
         fl_rd_ff    <= 1'b0;
         fl_wr_ff    <= 1'b0;
         fl_erase_ff <= 1'b0;
      end else if (I_CE) begin
         fl_rd_ff    <= 1'b0;
         fl_wr_ff    <= 1'b0;
         fl_erase_ff <= 1'b0;
         if (state_ff[0] && req_go && ps_ee_ff) begin
            // Data byte is dropped on purpose
            op_addr_ff  <= {eff_addr[FL_AW-1:PAGE_OFS_W], {PAGE_OFS_W{1'b0}}};
            op_data_ff  <= ERASED_BYTE;
            fl_erase_ff <= 1'b1;
         end else if (state_ff[0] && req_go) begin
            op_addr_ff <= eff_addr;
            op_data_ff <= I_XWR_DATA;
            fl_rd_ff   <= 1'b1;
         end else if (state_ff[1] && !I_SYS_RST) begin
            // Old contents masked in so no bit can rise
            op_data_ff <= op_data_ff & I_FL_RDATA;
            fl_wr_ff   <= 1'b1;
         end
      end
   end

   // Operation timer; a system reset drops any count left by a cut operation
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         cnt_ff <= '0;
      end else if (I_CE) begin
         if (I_SYS_RST) begin
            cnt_ff <= '0;
         end else if (state_ff[0] && req_go && ps_ee_ff) begin
            cnt_ff <= CNT_W'(P_ERASE_CYC - 1);
         end else if (state_ff[1]) begin
            cnt_ff <= CNT_W'(P_PROG_CYC - 1);
         end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
         end
      end
   end

   // Stall rises the cycle after the request is taken, so the CPU holds
   // its next instruction; it also holds interrupts for the whole operation.
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         stall_ff <= 1'b0;
      end else if (I_CE) begin
         stall_ff <= ~I_SYS_RST & (req_go | ((state_ff[1] | state_ff[2] | state_ff[3])
                     & ~op_done));
      end
   end

   assign O_PRDATA        = prdata_ff;
   assign O_PREADY        = pready_ff;
   assign O_PSLVERR       = pslverr_ff;
   assign O_XWR_TO_FLASH  = ps_we_ff;
   assign O_CPU_STALL     = stall_ff;
   assign O_IRQ_HOLD      = stall_ff;
   assign O_FLASH_ERR_RST = err_rst_ff;
   assign O_FL_RD         = fl_rd_ff;
   assign O_FL_WR         = fl_wr_ff;
   assign O_FL_ERASE      = fl_erase_ff;
   assign O_FL_ADDR       = op_addr_ff;
   assign O_FL_WDATA      = op_data_ff;

endmodule
`default_nettype wire

// ==== dv/fpg_flash_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpg_flash_model
   import fpg_pkg::*;
(
   input  wire logic             i_clk,
   input  wire logic             i_wr,
   input  wire logic             i_erase,
   input  wire logic [FL_AW-1:0] i_addr,
   input  wire logic [7:0]       i_wdata,
   output logic      [7:0]       o_rdata
);
   logic [7:0] mem [0:(1<<FL_AW)-1];
   initial foreach (mem[i]) mem[i] = ERASED_BYTE;
   assign o_rdata = mem[i_addr];
   // Cells can only lose charge on a write, never gain it
   always @(posedge i_clk) begin
      if (i_wr) mem[i_addr] <= mem[i_addr] & i_wdata;
      if (i_erase) begin
         for (int i = 0; i < 512; i++) begin
            mem[{i_addr[12:9], i[8:0]}] <= ERASED_BYTE;
         end
      end
   end
endmodule
`default_nettype wire

// ==== dv/fpg_flash_guard_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpg_flash_guard_chk
   import fpg_pkg::*;
#(
   parameter int unsigned P_PROG_CYC  = PROG_CYC,
   parameter int unsigned P_ERASE_CYC = ERASE_CYC
) (
   input wire logic             I_CLOCK,
   input wire logic             I_RST,
   input wire logic             I_XWR_REQ,
   input wire logic             I_XWR_SHORT,
   input wire logic [7:0]       I_FL_RDATA,
   input wire logic             O_CPU_STALL,
   input wire logic             O_IRQ_HOLD,
   input wire logic             O_FLASH_ERR_RST,
   input wire logic             O_FL_RD,
   input wire logic             O_FL_WR,
   input wire logic             O_FL_ERASE,
   input wire logic [FL_AW-1:0] O_FL_ADDR,
   input wire logic [7:0]       O_FL_WDATA,
   input wire logic             O_PSLVERR
);
   int unsigned stall_len;
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) stall_len <= 0;
      else if (O_CPU_STALL) stall_len <= stall_len + 1;
      else stall_len <= 0;
   end
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (I_RST);
   a_irq_hold_eq: assert property (O_IRQ_HOLD == O_CPU_STALL)
      else $error("irq hold differs from stall");
   a_stall_bound: assert property (stall_len <= P_ERASE_CYC + 4)
      else $error("stall too long");
   a_op_in_stall: assert property (O_FL_WR || O_FL_ERASE |-> O_CPU_STALL)
      else $error("array op without stall");
   a_stall_cause: assert property ($rose(O_CPU_STALL) |-> $past(I_XWR_REQ))
      else $error("stall without request");
   a_erase_base: assert property (O_FL_ERASE |-> O_FL_ADDR[PAGE_OFS_W-1:0] == '0)
      else $error("erase not at page base");
   a_wr_clears: assert property (O_FL_WR |-> (O_FL_WDATA & ~I_FL_RDATA) == 8'h00)
      else $error("write sets a bit");
   a_rd_then_wr: assert property (O_FL_WR |-> $past(O_FL_RD))
      else $error("write without prior read");
   a_short_mask: assert property ($rose(O_CPU_STALL) && $past(I_XWR_SHORT)
      |-> O_FL_ADDR[12:8] == '0)
      else $error("short write above first 256 bytes");
   a_err_no_op: assert property (O_FLASH_ERR_RST
      |-> !O_CPU_STALL && !O_FL_WR && !O_FL_ERASE)
      else $error("array op with fault reset");
   c_erase: cover property (O_FL_ERASE);
   c_prog: cover property (O_FL_WR);
   c_fault: cover property (O_FLASH_ERR_RST);
   c_slverr: cover property (O_PSLVERR);
endmodule
bind fpg_flash_guard fpg_flash_guard_chk #(
   .P_PROG_CYC(P_PROG_CYC),
   .P_ERASE_CYC(P_ERASE_CYC)
) chk_u (
   .I_CLOCK, .I_RST, .I_XWR_REQ, .I_XWR_SHORT, .I_FL_RDATA, .O_CPU_STALL, .O_IRQ_HOLD,
   .O_FLASH_ERR_RST, .O_FL_RD, .O_FL_WR, .O_FL_ERASE, .O_FL_ADDR, .O_FL_WDATA, .O_PSLVERR);
`default_nettype wire

// ==== dv/fpg_flash_guard_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpg_flash_guard_tb;
   import fpg_pkg::*;
   // Short counts keep the erase wait small
   localparam int PC = 8;
   localparam int EC = 16;
   logic        clk = 1'b0, rst = 1'b1, sys_rst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic        req = 1'b0, sht = 1'b0, st, irq, err, rd, wr, er, rdy, slv, steer;
   logic        saw_st, saw_err, e;
   logic [7:0]  paddr = 8'h00, xd = 8'h00, fwd, frd, d;
   logic [31:0] pwd = 32'h0, prd, r;
   logic [12:0] xa = 13'h0, fa, a, ea;
   int          errors = 0, check_count = 0, seed = 52, ref_mem [8192];
   fpg_flash_guard #(.P_PROG_CYC(PC), .P_ERASE_CYC(EC)) dut_u (
      .I_CLOCK(clk), .I_RST(rst), .I_CE(1'b1), .I_SYS_RST(sys_rst), .I_PSEL(psel),
      .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwd), .O_PRDATA(prd),
      .O_PREADY(rdy), .O_PSLVERR(slv), .I_XWR_REQ(req), .I_XWR_SHORT(sht), .I_XWR_ADDR(xa),
      .I_XWR_DATA(xd), .O_XWR_TO_FLASH(steer), .O_CPU_STALL(st), .O_IRQ_HOLD(irq),
      .O_FLASH_ERR_RST(err), .O_FL_RD(rd), .O_FL_WR(wr), .O_FL_ERASE(er), .O_FL_ADDR(fa),
      .O_FL_WDATA(fwd), .I_FL_RDATA(frd));
   fpg_flash_model flash_u (.i_clk(clk), .i_wr(wr), .i_erase(er), .i_addr(fa), .i_wdata(fwd),
      .o_rdata(frd));
   initial forever #4 clk = ~clk;
   task automatic wrap_up();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Leading edge wait keeps a release and the next setup in separate steps
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= ad;
      pwd <= wd;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (rdy !== 1'b1);
      r = prd;
      e = slv;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic xwr(input logic [12:0] xad, input logic [7:0] xdat, input logic s);
      @(posedge clk);
      req <= 1'b1;
      xa <= xad;
      xd <= xdat;
      sht <= s;
      @(posedge clk);
      req <= 1'b0;
      saw_st = 1'b0;
      saw_err = 1'b0;
      do begin
         @(posedge clk);
         chk("irq_hold", irq, st);
         saw_st |= st;
         saw_err |= err;
      end while (st === 1'b1);
   endtask
   task automatic sreset();
      @(posedge clk);
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
   endtask
   task automatic unlock();
      apb(1'b1, ADDR_KEY, KEY_FIRST);
      apb(1'b0, ADDR_KEY, 0);
      chk("lock_first", r, LK_FIRST);
      apb(1'b1, ADDR_KEY, KEY_SECOND);
      apb(1'b0, ADDR_KEY, 0);
      chk("lock_open", r, LK_OPEN);
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      wrap_up();
   end
   initial begin
      foreach (ref_mem[i]) ref_mem[i] = 255;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, ADDR_PS_CTRL, 0);
      chk("ps_ctrl", r, 32'h0);
      apb(1'b0, ADDR_SUPPLY_CTRL, 0);
      chk("supply", r & 32'ha0, 32'h80);
      apb(1'b0, ADDR_RESET_CAUSE, 0);
      chk("cause", r & 32'hc2, 32'h80);
      apb(1'b0, 8'h10, 0);
      chk("slverr", e, 1);
      // Monitor on, then selected, with no settling wait
      apb(1'b1, ADDR_SUPPLY_CTRL, 32'ha0);
      apb(1'b1, ADDR_RESET_CAUSE, 32'h02);
      for (int k = 0; k < 4; k++) begin
         a = (k == 3) ? 13'h1234 : (k == 2) ? 13'h0601 : 13'h0400;
         ea = (k == 3) ? (a & SHORT_ADDR_MASK) : a;
         d = 8'($random(seed));
         unlock();
         apb(1'b1, ADDR_PS_CTRL, 32'h1);
         xwr(a, d, k == 3);
         ref_mem[ea] &= d;
         chk("stall", saw_st, 1);
         chk("flash", flash_u.mem[ea], ref_mem[ea]);
         chk("steer", steer, 1);
         apb(1'b0, ADDR_KEY, 0);
         chk("relock", r, LK_LOCKED);
         apb(1'b1, ADDR_PS_CTRL, 0);
      end
      chk("short_hi", flash_u.mem[13'h1234], 255);
      unlock();
      apb(1'b1, ADDR_PS_CTRL, 32'h3);
      xwr(13'h0455, 8'($random(seed)), 1'b0);
      apb(1'b1, ADDR_PS_CTRL, 0);
      for (int i = 'h400; i < 'h600; i++) ref_mem[i] = 255;
      for (int i = 'h200; i < 'h800; i++) chk("page", flash_u.mem[i], ref_mem[i]);
      apb(1'b1, ADDR_PS_CTRL, 32'h1);
      xwr(13'h0601, 8'h00, 1'b0);
      chk("no_op", saw_st, 0);
      chk("keep", flash_u.mem[13'h0601], ref_mem[13'h0601]);
      unlock_dead: begin
         apb(1'b1, ADDR_KEY, KEY_FIRST);
         apb(1'b1, ADDR_KEY, KEY_SECOND);
         apb(1'b0, ADDR_KEY, 0);
         chk("dead", r, LK_DEAD);
      end
      sreset();
      unlock();
      xwr(13'h0601, 8'h00, 1'b0);
      chk("ram_path", saw_st, 0);
      for (int k = 0; k < 3; k++) begin
         sreset();
         if (k == 2) apb(1'b1, ADDR_KEY, KEY_FIRST);
         apb(1'b1, ADDR_KEY, (k == 1) ? KEY_SECOND : 8'h5a);
         apb(1'b0, ADDR_KEY, 0);
         chk("bad_key", r, LK_DEAD);
      end
      // Deliberately broken monitor setups, one per missing condition, then an intact setup that must leave no fault
      for (int k = 0; k < 4; k++) begin
         sreset();
         apb(1'b1, ADDR_SUPPLY_CTRL, (k == 1) ? 32'h80 : (k == 2) ? 32'h20 : 32'ha0);
         apb(1'b1, ADDR_RESET_CAUSE, (k == 0) ? 32'h0 : 32'h2);
         if (k == 3) begin
            sreset();
         end else begin
            unlock();
            apb(1'b1, ADDR_PS_CTRL, 32'h1);
            xwr(13'h0602, 8'h00, 1'b0);
            chk("err_rst", saw_err, 1);
            chk("keep2", flash_u.mem[13'h0602], ref_mem[13'h0602]);
            sreset();
         end
         apb(1'b0, ADDR_RESET_CAUSE, 0);
         chk("fault", r[6], k != 3);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
